// ---- logic/mab_pkg.sv ----
// Shared constants and types for the multiply-accumulate block.
// Assumes a single system clock and an AXI4-Lite register slave.
package mab_pkg;
  // ==========================================================
  // Datapath sizes
  localparam int OP_W = 18;
  localparam int NIB_W = 9;
  localparam int WIDE_W = 36;
  localparam int RES_W = 36;
  localparam int ACC_W = 52;
  localparam int UNIT_N = 4;
  localparam int FIFO_D = 8;
  localparam int PROD_W = 74;
  // ==========================================================
  // Register map
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CFG_WIDE = 0;
  localparam int CFG_LO9 = 1;
  localparam int CFG_HI9 = 2;
  localparam int CFG_CHAIN = 3;
  localparam int CFG_CASC = 4;
  localparam int CFG_W = 5;
  localparam logic [4:0] CFG_RST = 5'h00;
  // ==========================================================
  // Q1.15 rounding and saturation of Q2.30 results
  localparam logic signed [73:0] RND_HALF = 74'sh4000;
  localparam logic signed [73:0] FRAC_MASK = 74'sh7fff;
  localparam logic signed [73:0] SAT_MAX = 74'sh7fffffff;
  localparam logic signed [73:0] SAT_MIN = 74'sh3ffffffffff80000000;
  // ==========================================================
  // Per-half post-multiplier modes
  typedef enum logic [1:0] {
    MAB_SIMPLE = 2'h0,
    MAB_MAC = 2'h1,
    MAB_ADD2 = 2'h3,
    MAB_ADD4 = 2'h2
  } mab_mode_t;
endpackage : mab_pkg

// ---- logic/mab_fifo.sv ----
// Sample FIFO with a registered output stage.
// Assumes synchronous inputs on sys_clk; depth is a power of two.
`timescale 1ns/1ps
module mab_fifo #(
  parameter int W = mab_pkg::OP_W,
  parameter int D = mab_pkg::FIFO_D
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(D+1)-1:0] level
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);

  if (W < 1 || D < 2 || (D & (D - 1)) != 0) begin : g_bad
    $error("mab_fifo: W must be positive and D a power of two of at least 2");
  end

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic ov;
    logic [W-1:0] od;
    logic irdy;
  } mab_fifo_st_t;

  mab_fifo_st_t s_q;
  mab_fifo_st_t s_d;
  logic push;
  logic pop;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    push = in_valid && s_q.irdy;
    pop = (s_q.cnt != '0) && (!s_q.ov || out_ready);
    if (s_q.ov && out_ready) begin
      s_d.ov = 1'b0;
    end
    if (pop) begin
      s_d.od = s_q.mem[s_q.rp];
      s_d.ov = 1'b1;
      s_d.rp = s_q.rp + AW'(1);
    end
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = s_q.wp + AW'(1);
    end
    s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
    s_d.irdy = s_d.cnt < CW'(D);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.irdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready = s_q.irdy;
  assign out_valid = s_q.ov;
  assign out_data = s_q.od;
  assign level = s_q.cnt + CW'(s_q.ov);
endmodule : mab_fifo

// ---- logic/mab_core.sv ----
// Multiply-accumulate block: four 18x18 units, halves with own modes.
// Assumes row controls synchronous to sys_clk; registers over AXI4-Lite.
// What this block does
// - Eight 9x9, four 18x18 or one 36x36 multipliers, each product output.
// - The 36x36 product is correct for any mix of operand signedness.
// - Products may feed the internal adder or accumulator instead of leaving.
// - Operand A registers can shift sample to sample along the units.
// - Q1.15 rounding and saturation are offered on results.
// - Modes are simple, multiply-accumulate, two-product sum, four-product sum.
// - Accumulation only with 18x18 operands, two 52-bit accumulators.
// - Two-product sum gives two or four adders, four-product sum one or two.
// - Each half picks its own mode and operand size.
// - Longer filters cascade the chain onward; the fabric adds partial sums.
// - The operand chain leaves the block through a chain output.
// - Four units, each a full 18x18 multiplier, 36 bits in and out.
// - Each row gives its unit an enable and a clear.
// - Rows carry two operands and one result; enables and clears split by row.
`timescale 1ns/1ps
module mab_core (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic row0_clk_enable,
  input wire logic row1_clk_enable,
  input wire logic row2_clk_enable,
  input wire logic row3_clk_enable,
  input wire logic row0_async_clear,
  input wire logic row1_async_clear,
  input wire logic row2_async_clear,
  input wire logic row3_async_clear,
  input wire logic a_signed,
  input wire logic b_signed,
  input wire logic pair_lo_product_saturate,
  input wire logic pair_lo_product_round,
  input wire logic pair_hi_product_saturate,
  input wire logic pair_hi_product_round,
  input wire logic adder_lo_round,
  input wire logic adder_hi_round,
  input wire logic adder_lo_add_or_sub,
  input wire logic adder_hi_add_or_sub,
  input wire logic accum_lo_saturate,
  input wire logic accum_hi_saturate,
  input wire logic accum_lo_load,
  input wire logic accum_hi_load,
  input wire logic [1:0] half_lo_mode_sel,
  input wire logic [1:0] half_hi_mode_sel,
  input wire logic [3:0][17:0] op_a,
  input wire logic [3:0][17:0] op_b,
  output logic [3:0][35:0] res_out,
  input wire logic [17:0] chain_in,
  output logic [17:0] chain_out,
  input wire logic [17:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  typedef struct packed {
    logic [3:0][17:0] a;
    logic [3:0][17:0] b;
    logic [3:0][35:0] res;
    logic [1:0][51:0] acc;
    logic [17:0] chain;
    logic [4:0] cfg;
    logic aw_got;
    logic w_got;
    logic [3:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awrdy;
    logic wrdy;
    logic bvld;
    logic [1:0] bresp;
    logic arrdy;
    logic rvld;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mab_state_t;

  // ==========================================================
  // Helpers
  function automatic logic signed [73:0] sx(input logic [35:0] v, input int unsigned w, input logic sg);
    logic [73:0] m;
    m = (74'd1 << w) - 74'd1;
    sx = (sg && v[w-1]) ? (74'(v) | ~m) : (74'(v) & m);
  endfunction : sx

  function automatic logic signed [73:0] rs(input logic signed [73:0] v, input logic rnd, input logic sat);
    logic signed [73:0] r;
    r = rnd ? ((v + mab_pkg::RND_HALF) & ~mab_pkg::FRAC_MASK) : v;
    if (sat && r > mab_pkg::SAT_MAX) begin
      r = mab_pkg::SAT_MAX;
    end else if (sat && r < mab_pkg::SAT_MIN) begin
      r = mab_pkg::SAT_MIN;
    end
    rs = r;
  endfunction : rs

  mab_state_t s_q;
  mab_state_t s_d;
  logic [3:0] en;
  logic [3:0] clr;
  logic wide;
  logic chain_on;
  logic casc;
  logic adv;
  logic [17:0] src;
  logic fifo_ov;
  logic [17:0] fifo_od;
  logic [3:0] fifo_lvl;
  logic signed [3:0][73:0] p18;
  logic signed [3:0][73:0] p9l;
  logic signed [3:0][73:0] p9h;
  logic signed [73:0] pw;
  mab_pkg::mab_mode_t md_lo;
  mab_pkg::mab_mode_t md_hi;

  assign en = {row3_clk_enable, row2_clk_enable, row1_clk_enable, row0_clk_enable};
  assign clr = {row3_async_clear, row2_async_clear, row1_async_clear, row0_async_clear};
  assign md_lo = mab_pkg::mab_mode_t'(half_lo_mode_sel);
  assign md_hi = mab_pkg::mab_mode_t'(half_hi_mode_sel);
  assign wide = s_q.cfg[mab_pkg::CFG_WIDE];
  assign chain_on = s_q.cfg[mab_pkg::CFG_CHAIN];
  assign casc = s_q.cfg[mab_pkg::CFG_CASC];
  assign src = casc ? chain_in : fifo_od;
  assign adv = chain_on && en[0] && (casc || fifo_ov);

  // ==========================================================
  // Sample buffer feeding the operand chain
  mab_fifo #(
    .W(mab_pkg::OP_W),
    .D(mab_pkg::FIFO_D)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_od),
    .out_valid(fifo_ov),
    .out_ready(chain_on && !casc && en[0]),
    .level(fifo_lvl)
  );

  // ==========================================================
  // Multipliers
  for (genvar u = 0; u < mab_pkg::UNIT_N; u++) begin : g_mul
    assign p18[u] = sx(36'(s_q.a[u]), mab_pkg::OP_W, a_signed) * sx(36'(s_q.b[u]), mab_pkg::OP_W, b_signed);
    assign p9l[u] = sx(36'(s_q.a[u][8:0]), mab_pkg::NIB_W, a_signed) * sx(36'(s_q.b[u][8:0]), mab_pkg::NIB_W, b_signed);
    assign p9h[u] = sx(36'(s_q.a[u][17:9]), mab_pkg::NIB_W, a_signed) * sx(36'(s_q.b[u][17:9]), mab_pkg::NIB_W, b_signed);
  end
  assign pw = sx({s_q.a[1], s_q.a[0]}, mab_pkg::WIDE_W, a_signed) * sx({s_q.b[1], s_q.b[0]}, mab_pkg::WIDE_W, b_signed);

  // ==========================================================
  // Next state
  always_comb begin
    logic [3:0][35:0] rn;
    logic [1:0][51:0] accn;
    logic signed [1:0][73:0] s2;
    logic signed [1:0][73:0] l2;
    logic signed [1:0][73:0] h2;
    logic signed [73:0] t;
    logic signed [73:0] ac;
    mab_pkg::mab_mode_t md;
    logic z9;
    logic rp;
    logic sp;
    logic ra;
    logic ad;
    logic asat;
    logic ald;
    rn = s_q.res;
    accn = s_q.acc;
    s2 = '0;
    l2 = '0;
    h2 = '0;
    t = '0;
    ac = '0;
    md = mab_pkg::MAB_SIMPLE;
    z9 = 1'b0;
    rp = 1'b0;
    sp = 1'b0;
    ra = 1'b0;
    ad = 1'b0;
    asat = 1'b0;
    ald = 1'b0;
    s_d = s_q;

    // Register slave, write side
    if (awvalid && s_q.awrdy) begin
      s_d.aw_got = 1'b1;
      s_d.awa = awaddr;
      s_d.awrdy = 1'b0;
    end
    if (wvalid && s_q.wrdy) begin
      s_d.w_got = 1'b1;
      s_d.wd = wdata;
      s_d.ws = wstrb;
      s_d.wrdy = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvld) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvld = 1'b1;
      s_d.bresp = (s_q.awa == mab_pkg::ADDR_CFG || s_q.awa == mab_pkg::ADDR_STAT) ?
                  mab_pkg::RESP_OKAY : mab_pkg::RESP_SLVERR;
      if (s_q.awa == mab_pkg::ADDR_CFG && s_q.ws[0]) begin
        s_d.cfg = s_q.wd[mab_pkg::CFG_W-1:0];
      end
    end
    if (s_q.bvld && bready) begin
      s_d.bvld = 1'b0;
      s_d.awrdy = 1'b1;
      s_d.wrdy = 1'b1;
    end

    // Register slave, read side
    if (arvalid && s_q.arrdy) begin
      s_d.arrdy = 1'b0;
      s_d.rvld = 1'b1;
      s_d.rresp = mab_pkg::RESP_OKAY;
      if (araddr == mab_pkg::ADDR_CFG) begin
        s_d.rdata = 32'(s_q.cfg);
      end else if (araddr == mab_pkg::ADDR_STAT) begin
        s_d.rdata = 32'({fifo_ov, fifo_lvl});
      end else begin
        s_d.rdata = 32'h0;
        s_d.rresp = mab_pkg::RESP_SLVERR;
      end
    end
    if (s_q.rvld && rready) begin
      s_d.rvld = 1'b0;
      s_d.arrdy = 1'b1;
    end

    // Operand registers and chain
    for (int u = 0; u < mab_pkg::UNIT_N; u++) begin
      if (clr[u]) begin
        s_d.a[u] = '0;
        s_d.b[u] = '0;
      end else begin
        if (en[u]) begin
          s_d.b[u] = op_b[u];
          if (!chain_on) begin
            s_d.a[u] = op_a[u];
          end
        end
        if (adv) begin
          s_d.a[u] = (u == 0) ? src : s_q.a[(u + mab_pkg::UNIT_N - 1) % mab_pkg::UNIT_N];
        end
      end
    end
    if (adv) begin
      s_d.chain = s_q.a[3];
    end

    // Post-multiplier logic per half
    for (int h = 0; h < 2; h++) begin
      md = (h == 0) ? md_lo : md_hi;
      z9 = s_q.cfg[(h == 0) ? mab_pkg::CFG_LO9 : mab_pkg::CFG_HI9];
      rp = (h == 0) ? pair_lo_product_round : pair_hi_product_round;
      sp = (h == 0) ? pair_lo_product_saturate : pair_hi_product_saturate;
      ra = (h == 0) ? adder_lo_round : adder_hi_round;
      ad = (h == 0) ? adder_lo_add_or_sub : adder_hi_add_or_sub;
      asat = (h == 0) ? accum_lo_saturate : accum_hi_saturate;
      ald = (h == 0) ? accum_lo_load : accum_hi_load;
      s2[h] = ad ? p18[2*h] + p18[2*h+1] : p18[2*h] - p18[2*h+1];
      l2[h] = ad ? p9l[2*h] + p9l[2*h+1] : p9l[2*h] - p9l[2*h+1];
      h2[h] = ad ? p9h[2*h] + p9h[2*h+1] : p9h[2*h] - p9h[2*h+1];
      unique case (md)
        mab_pkg::MAB_SIMPLE: begin
          for (int k = 2*h; k < 2*h+2; k++) begin
            t = rs(p18[k], rp, sp);
            rn[k] = z9 ? {p9h[k][17:0], p9l[k][17:0]} : t[35:0];
          end
        end
        mab_pkg::MAB_MAC: begin
          ac = sx(36'(s_q.acc[h][35:0]), mab_pkg::WIDE_W, 1'b0) | (74'(s_q.acc[h]) & ~74'hfffffffff);
          ac = sx(ac[35:0] | 36'h0, mab_pkg::WIDE_W, 1'b0) | (s_q.acc[h][51] ? ~74'hfffffffffffff : 74'h0)
               | (74'(s_q.acc[h]) & 74'hffff000000000);
          t = ald ? p18[2*h] : (ad ? ac + p18[2*h] : ac - p18[2*h]);
          t = rs(t, ra, asat);
          accn[h] = t[51:0];
          rn[2*h] = t[35:0];
          rn[2*h+1] = {{20{t[51]}}, t[51:36]};
        end
        mab_pkg::MAB_ADD2, mab_pkg::MAB_ADD4: begin
          t = rs(s2[h], ra, sp);
          rn[2*h] = z9 ? l2[h][35:0] : t[35:0];
          rn[2*h+1] = z9 ? h2[h][35:0] : t[71:36];
        end
      endcase
    end
    if (md_lo == mab_pkg::MAB_ADD4) begin
      t = rs(s2[0] + s2[1], adder_lo_round, pair_lo_product_saturate);
      rn[0] = s_q.cfg[mab_pkg::CFG_LO9] ? 36'(l2[0] + l2[1]) : t[35:0];
      rn[1] = s_q.cfg[mab_pkg::CFG_LO9] ? 36'(h2[0] + h2[1]) : t[71:36];
      rn[2] = '0;
      rn[3] = '0;
    end
    if (wide) begin
      rn[0] = pw[35:0];
      rn[1] = pw[71:36];
      rn[2] = '0;
      rn[3] = '0;
    end
    for (int u = 0; u < mab_pkg::UNIT_N; u++) begin
      if (clr[u]) begin
        s_d.res[u] = '0;
      end else if (en[u]) begin
        s_d.res[u] = rn[u];
      end
    end
    for (int h = 0; h < 2; h++) begin
      md = (h == 0) ? md_lo : md_hi;
      if (clr[2*h+1]) begin
        s_d.acc[h] = '0;
      end else if (en[2*h+1] && md == mab_pkg::MAB_MAC && !wide) begin
        s_d.acc[h] = accn[h];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.cfg <= mab_pkg::CFG_RST;
      s_q.awrdy <= 1'b1;
      s_q.wrdy <= 1'b1;
      s_q.arrdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign res_out = s_q.res;
  assign chain_out = s_q.chain;
  assign awready = s_q.awrdy;
  assign wready = s_q.wrdy;
  assign bvalid = s_q.bvld;
  assign bresp = s_q.bresp;
  assign arready = s_q.arrdy;
  assign rvalid = s_q.rvld;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_lo_mac(logic ld);
    md_lo == mab_pkg::MAB_MAC && !wide && row1_clk_enable && !row1_async_clear && accum_lo_load == ld
      && adder_lo_add_or_sub && !adder_lo_round && !accum_lo_saturate;
  endsequence

  chk_acc_load: assert property (s_lo_mac(1'b1) |=> s_q.acc[0] == $past(p18[0][51:0]))
    else $error("accumulator load did not take the product");
  chk_acc_two_step: assert property (s_lo_mac(1'b1) ##1 s_lo_mac(1'b0) |=>
    s_q.acc[0] == 52'($past(p18[0][51:0], 2) + $past(p18[0][51:0])))
    else $error("accumulator did not add to the loaded value");
  chk_wide_prod: assert property (wide && en[0] && !clr[0] && en[1] && !clr[1] |=>
    {s_q.res[1], s_q.res[0]} == $past(pw[71:0]))
    else $error("wide product mismatch");
  chk_simple_lo: assert property (md_lo == mab_pkg::MAB_SIMPLE && !wide && !s_q.cfg[mab_pkg::CFG_LO9] && en[0]
    && !clr[0] && !pair_lo_product_round && !pair_lo_product_saturate |=> s_q.res[0] == $past(p18[0][35:0]))
    else $error("simple product mismatch");
  chk_add2_lo: assert property (md_lo == mab_pkg::MAB_ADD2 && !wide && !s_q.cfg[mab_pkg::CFG_LO9] && en[0]
    && !clr[0] && adder_lo_add_or_sub && !adder_lo_round && !pair_lo_product_saturate
    |=> s_q.res[0] == $past(36'(p18[0] + p18[1])))
    else $error("two-product sum mismatch");
  chk_sat_range: assert property (md_lo == mab_pkg::MAB_SIMPLE && !wide && !s_q.cfg[mab_pkg::CFG_LO9] && en[0]
    && !clr[0] && pair_lo_product_saturate |=> $signed(s_q.res[0]) <= 36'sh07fffffff
    && $signed(s_q.res[0]) >= -36'sh080000000)
    else $error("saturated result out of range");
  chk_chain_shift: assert property (adv && !clr[1] |=> s_q.a[1] == $past(s_q.a[0]))
    else $error("chain did not shift");
  chk_chain_out: assert property (adv ##1 !adv [*2] |=> chain_out == $past(s_q.a[3], 3))
    else $error("chain output lost its sample");
  chk_row_clear: assert property (row2_async_clear |=> s_q.res[2] == '0 && s_q.a[2] == '0)
    else $error("row clear did not clear unit");
endmodule : mab_core

// ---- sim/mab_fabric_src.sv ----
// Fabric-side sample source feeding the block's sample stream.
// Assumes the bench's sys_clk and nrst; one sample per handshake.
`timescale 1ns/1ps
module mab_fabric_src #(
  parameter logic [17:0] BASE = 18'h200,
  parameter int N = 12
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic go,
  output logic [4:0] sent,
  output logic [17:0] sample_data,
  output logic sample_valid,
  input wire logic sample_ready
);
  // ==========================================================
  // Offer a sample, hold it until taken, then idle one cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sent <= 5'h00;
      sample_valid <= 1'b0;
      sample_data <= 18'h3ffff;
    end else if (sample_valid && sample_ready) begin
      sent <= sent + 5'h01;
      sample_valid <= 1'b0;
      sample_data <= ~sample_data; // Released line shows no stale value
    end else if (go && !sample_valid && int'(sent) < N) begin
      sample_valid <= 1'b1;
      sample_data <= BASE + 18'(sent);
    end
  end
endmodule : mab_fabric_src

// ---- sim/multiply_accumulate_block_bench.sv ----
// Self-checking bench for the multiply-accumulate block.
// Assumes the core, its FIFO and the fabric sample source are compiled first.
`timescale 1ns/1ps
module multiply_accumulate_block_bench;
  logic sys_clk, nrst, go, sa, sb;
  logic [3:0] en, cl, awaddr, araddr, wstrb;
  logic [1:0] psat, prnd, arnd, aos, asat, ald, mlo, mhi, bresp, rresp, r;
  logic [3:0][17:0] op_a, op_b;
  logic [3:0][35:0] res;
  logic [17:0] cin, cout, sample_data;
  logic sample_valid, sample_ready, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [4:0] sent;
  logic [73:0] p, q;
  logic [51:0] acc, q0;
  int miscompares, compares;
  assign acc = {res[1][15:0], res[0]};
  always #50 sys_clk = ~sys_clk;
  mab_core DUT (
    .sys_clk, .nrst, .row0_clk_enable(en[0]), .row1_clk_enable(en[1]), .row2_clk_enable(en[2]),
    .row3_clk_enable(en[3]), .row0_async_clear(cl[0]), .row1_async_clear(cl[1]), .row2_async_clear(cl[2]),
    .row3_async_clear(cl[3]), .a_signed(sa), .b_signed(sb), .pair_lo_product_saturate(psat[0]),
    .pair_lo_product_round(prnd[0]), .pair_hi_product_saturate(psat[1]), .pair_hi_product_round(prnd[1]),
    .adder_lo_round(arnd[0]), .adder_hi_round(arnd[1]), .adder_lo_add_or_sub(aos[0]),
    .adder_hi_add_or_sub(aos[1]), .accum_lo_saturate(asat[0]), .accum_hi_saturate(asat[1]),
    .accum_lo_load(ald[0]), .accum_hi_load(ald[1]), .half_lo_mode_sel(mlo), .half_hi_mode_sel(mhi),
    .op_a, .op_b, .res_out(res), .chain_in(cin), .chain_out(cout), .sample_data, .sample_valid, .sample_ready,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );
  mab_fabric_src SRC (.sys_clk, .nrst, .go, .sent, .sample_data, .sample_valid, .sample_ready);
  // ==========================================================
  // Helpers
  task automatic stop_test;
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [143:0] g, input logic [143:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  function automatic logic [73:0] mul(input logic [35:0] a, input logic [35:0] b, input int w,
                                      input logic xs, input logic ys);
    logic [73:0] x;
    logic [73:0] y;
    x = 74'(a);
    y = 74'(b);
    for (int i = w; i < 74; i++) begin
      x[i] = xs & a[w-1];
      y[i] = ys & b[w-1];
    end
    return x * y;
  endfunction : mul
  // ==========================================================
  // Register bus master
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    rs = bresp;
    if (n >= 50) begin
      miscompares++;
      stop_test;
    end
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [33:0] e);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    chk({rresp, rdata}, e);
    if (n >= 50) begin
      miscompares++;
      stop_test;
    end
  endtask : rchk
  task automatic wcfg(input logic [31:0] v);
    wr(mab_pkg::ADDR_CFG, v, 4'hf, r);
    chk(r, mab_pkg::RESP_OKAY);
  endtask : wcfg
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    stop_test;
  end
  // ==========================================================
  // Scenarios
  initial begin
    {sys_clk, nrst, go, sa, sb, awvalid, wvalid, bready, arvalid, rready} = '0;
    {en, cl, psat, prnd, arnd, aos, asat, ald, mlo, mhi} = 24'hf0_0000;
    {op_a, op_b, cin, awaddr, araddr, wstrb, wdata} = '0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    chk(res, '0);
    rchk(mab_pkg::ADDR_CFG, {mab_pkg::RESP_OKAY, 27'h0, mab_pkg::CFG_RST});
    wr(mab_pkg::ADDR_CFG, 32'h1f, 4'h0, r);
    rchk(mab_pkg::ADDR_CFG, {mab_pkg::RESP_OKAY, 32'h0});
    wr(4'h8, 32'h1f, 4'hf, r);
    chk(r, mab_pkg::RESP_SLVERR);
    rchk(4'h8, {mab_pkg::RESP_SLVERR, 32'h0});
    wr(mab_pkg::ADDR_STAT, 32'h1f, 4'hf, r);
    rchk(mab_pkg::ADDR_STAT, {mab_pkg::RESP_OKAY, 32'h0});
    wcfg(32'h1f);
    rchk(mab_pkg::ADDR_CFG, {mab_pkg::RESP_OKAY, 32'h1f});
    wcfg(32'h0);
    for (int s = 0; s < 2; s++) begin
      sa <= s[0];
      sb <= s[0];
      for (int u = 0; u < 4; u++) begin
        op_a[u] <= {u[1:0], 16'hc3a5};
        op_b[u] <= {~u[1:0], 16'h5e71};
      end
      tick(3);
      for (int u = 0; u < 4; u++) chk(res[u], 36'(mul(36'(op_a[u]), 36'(op_b[u]), 18, s[0], s[0])));
    end
    p = mul(36'(op_a[1]), 36'(op_b[1]), 18, 1'b1, 1'b1);
    cl <= 4'h4;
    en[1] <= 1'b0;
    op_a[1] <= 18'h00001;
    tick(3);
    chk(res[2], 36'h0);
    chk(res[1], p[35:0]);
    cl <= 4'h0;
    en[1] <= 1'b1;
    wcfg(32'h1 << mab_pkg::CFG_WIDE);
    op_a[1:0] <= 36'h987654321;
    op_b[1:0] <= 36'hf0123abcd;
    for (int s = 0; s < 4; s++) begin
      sa <= s[0];
      sb <= s[1];
      tick(3);
      p = mul(36'h987654321, 36'hf0123abcd, 36, s[0], s[1]);
      chk({res[1], res[0]}, p[71:0]);
      chk({res[3], res[2]}, 72'h0);
    end
    wcfg((32'h1 << mab_pkg::CFG_LO9) | (32'h1 << mab_pkg::CFG_HI9));
    tick(3);
    for (int u = 0; u < 4; u++) chk(res[u], {18'(mul(36'(op_a[u][17:9]), 36'(op_b[u][17:9]), 9, 1'b1, 1'b1)),
                                            18'(mul(36'(op_a[u][8:0]), 36'(op_b[u][8:0]), 9, 1'b1, 1'b1))});
    wcfg(32'h0);
    mlo <= 2'h3;
    mhi <= 2'h3;
    for (int o = 0; o < 2; o++) begin
      aos <= {o[0], o[0]};
      tick(3);
      for (int h = 0; h < 2; h++) begin
        p = mul(36'(op_a[2*h]), 36'(op_b[2*h]), 18, 1'b1, 1'b1);
        q = mul(36'(op_a[2*h+1]), 36'(op_b[2*h+1]), 18, 1'b1, 1'b1);
        p = o[0] ? p + q : p - q;
        chk({res[2*h+1], res[2*h]}, p[71:0]);
      end
    end
    mlo <= 2'h2;
    mhi <= 2'h0;
    op_a <= {4{18'h20000}};
    op_b <= {4{18'h20000}};
    for (int t = 0; t < 2; t++) begin
      psat <= {t[0], t[0]};
      tick(3);
      chk({res[1], res[0]}, t ? 72'h7fffffff : 72'h1000000000);
      chk(res[3], 36'h0);
    end
    mlo <= 2'h0;
    tick(3);
    chk({res[3], res[0]}, {36'h7fffffff, 36'h7fffffff});
    psat <= 2'h0;
    prnd <= 2'h3;
    op_a[0] <= 18'h01234;
    op_b[0] <= 18'h3f567;
    tick(3);
    p = (mul(36'h01234, 36'h3f567, 18, 1'b1, 1'b1) + 74'h4000) & ~74'h7fff;
    chk(res[0], p[35:0]);
    prnd <= 2'h0;
    wcfg(32'h1 << mab_pkg::CFG_HI9);
    mlo <= 2'h1;
    ald <= 2'h1;
    aos <= 2'h3;
    op_b[0] <= 18'h3ff45;
    op_a[1] <= 18'h0;
    tick(4);
    p = mul(36'h01234, 36'h3ff45, 18, 1'b1, 1'b1);
    chk(acc, p[51:0]);
    chk(res[2], {18'(mul(36'h100, 36'h100, 9, 1'b1, 1'b1)), 18'h0});
    ald <= 2'h0;
    for (int o = 1; o >= 0; o--) begin
      aos[0] <= o[0];
      tick(3);
      q0 = acc;
      tick(3);
      chk(52'(acc - q0), o ? 52'(p * 3) : 52'(-(p * 3)));
      chk(res[1][35:16], {20{res[1][15]}});
    end
    mlo <= 2'h0;
    wcfg((32'h1 << mab_pkg::CFG_CHAIN) | (32'h1 << mab_pkg::CFG_CASC));
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk);
      cin <= 18'h100 + 18'(i);
      if (i >= 6) chk(cout, 18'h100 + 18'(i - 6));
    end
    en[0] <= 1'b0;
    wcfg(32'h1 << mab_pkg::CFG_CHAIN);
    go <= 1'b1;
    tick(40);
    chk({sample_ready, sent}, {1'b0, 5'd9});
    rchk(mab_pkg::ADDR_STAT, {mab_pkg::RESP_OKAY, 32'h19});
    en[0] <= 1'b1;
    tick(40);
    chk({sent, cout}, {5'd12, 18'h207});
    rchk(mab_pkg::ADDR_STAT, {mab_pkg::RESP_OKAY, 32'h0});
    cl <= 4'hf;
    tick(3);
    chk(res, '0);
    stop_test;
  end
endmodule : multiply_accumulate_block_bench
